// ==== pss_sram_port.sv ====
`default_nettype none
// Behaviour
// R1 - selected only when all three enables active
// R2 - global write or all lanes writes everything
// R3 - output high impedance after write until strobe
// R4 - controller deselects before requesting sleep
// R5 - data pins high impedance on leaving sleep
// R6 - controller waits power-up interval before access
// R7 - byte-write gate writes only enabled lanes
module pss_sram_port
  import pss_pkg::*;
#(
  parameter int POWER_CYC = PSS_POWER_CYC,
  parameter int DEPTH = 1 << PSS_ADDR_W
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [PSS_ADDR_W-1:0] addr,
  input wire logic chip_enable_primary_n,
  input wire logic chip_enable_second,
  input wire logic chip_enable_third_n,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic all_bytes_write_n,
  input wire logic byte_write_gate_n,
  input wire logic [PSS_LANES-1:0] byte_lane_write_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic [PSS_DATA_W-1:0] dq_in,
  output logic [PSS_DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic sleeping,
  output logic powered_up
);
  // ==========================================================
  // timing
  // a strobe edge with the part selected starts an access; read data and the bus
  // drive follow and are refreshed every idle cycle while the access stays active
  // a write leaves the bus released until the next strobe, so a controller that
  // turns the bus around never meets this part driving against it
  // output enable is a pin and passes two flops, so it acts three edges late
  // sleep needs the part idle: a deselecting strobe ends the access first
  // memory contents survive reset; only the control state clears

  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [PSS_ADDR_W-1:0] addr;
    logic active;
    logic rd_p1;
    logic rd_p2;
    logic wr_hold;
    logic [PSS_DATA_W-1:0] q;
    logic drive;
    logic [1:0] oe_sync;
    logic oe;
    logic [1:0] zz_sync;
    logic sleeping;
    logic [31:0] pwr_cnt;
    logic powered_up;
  } pss_state_s;

  pss_state_s st_r;
  pss_state_s st_nxt;
  logic [PSS_DATA_W-1:0] mem_r [DEPTH];
  logic [PSS_LANES-1:0] lane_we;
  logic selected;
  logic strobe;
  logic ctrl_only;
  logic do_write;
  logic [PSS_ADDR_W-1:0] cur_addr;
  logic [PSS_ADDR_W-1:0] burst_addr;
  logic rst_n_s;

  assign rst_n_s = st_r.rst_sync[1];

  // ==========================================================
  // access decode
  // enables and strobes are launched off sys_clk by the controller: no synchroniser
  assign selected = ~chip_enable_primary_n & chip_enable_second & ~chip_enable_third_n; // R1
  assign strobe = ~proc_addr_strobe_n | ~ctrl_addr_strobe_n;
  // processor strobe never starts a write; the controller strobe may
  assign ctrl_only = proc_addr_strobe_n & ~ctrl_addr_strobe_n;
  // burst counter wraps inside an aligned group of four words
  assign burst_addr = {st_r.addr[PSS_ADDR_W-1:2], st_r.addr[1:0] + 2'h1};

  // ==========================================================
  // lane write decode
  // one instance per byte lane
  for (genvar g = 0; g < PSS_LANES; g++) begin : g_lane
    pss_lane_write u_lane (
      .all_bytes_write_n(all_bytes_write_n),
      .byte_write_gate_n(byte_write_gate_n),
      .lane_write_n(byte_lane_write_n[g]),
      .lane_we(lane_we[g])
    );
  end

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rst_sync = {st_r.rst_sync[0], 1'b1};
    st_nxt.zz_sync = {st_r.zz_sync[0], sleep_request};
    st_nxt.oe_sync = {st_r.oe_sync[0], output_enable_n};
    cur_addr = st_r.addr;
    do_write = 1'b0;
    st_nxt.rd_p1 = 1'b0;

    // ==========================================================
    // power-up tracking
    // accesses before powered_up are ignored, not queued
    if (st_r.pwr_cnt != POWER_CYC) begin
      st_nxt.pwr_cnt = st_r.pwr_cnt + 32'h1;
    end else begin
      st_nxt.powered_up = 1'b1;
    end

    // ==========================================================
    // sleep entry and exit
    // the request pin passes two flops before it is acted on
    if (st_r.zz_sync[1]) begin
      // sleep only honoured while deselected; the controller must arrange that
      if (!st_r.active) begin // R4
        st_nxt.sleeping = 1'b1;
      end
    end else begin
      st_nxt.sleeping = 1'b0;
    end

    // ==========================================================
    // accesses
    if (st_r.sleeping) begin
      st_nxt.drive = 1'b0; // R5
      st_nxt.rd_p2 = 1'b0;
      st_nxt.wr_hold = 1'b0;
    end else if (st_r.powered_up) begin // R6
      if (strobe) begin
        if (selected) begin // R1
          st_nxt.active = 1'b1;
          st_nxt.addr = addr;
          cur_addr = addr;
          st_nxt.wr_hold = 1'b0; // R3
          if (ctrl_only && (lane_we != '0)) begin
            do_write = 1'b1;
            st_nxt.wr_hold = 1'b1;
          end else begin
            st_nxt.rd_p1 = 1'b1;
          end
        end else begin
          st_nxt.active = 1'b0;
        end
      end else if (st_r.active) begin
        // address advance happens only after a selected strobe
        if (!burst_advance_n) begin
          cur_addr[1:0] = burst_addr[1:0];
          st_nxt.addr[1:0] = burst_addr[1:0] & PSS_BURST_MASK;
        end
        if (lane_we != '0) begin
          do_write = 1'b1;
          st_nxt.wr_hold = 1'b1;
        end else if (!st_r.wr_hold) begin
          // after a write the bus stays quiet until a fresh strobe
          st_nxt.rd_p1 = 1'b1; // R3
        end
      end
      st_nxt.rd_p2 = st_r.rd_p1;
      if (st_r.rd_p1) begin
        st_nxt.q = mem_r[st_r.addr];
      end
      // deselect turns the drivers off one cycle late (double-cycle deselect)
      st_nxt.drive = st_r.rd_p1 & ~st_nxt.wr_hold; // R3
    end

    // ==========================================================
    // output enable
    // gated on the next-state drive flag so dq_oe stays registered, with no cycle of lag behind drive
    st_nxt.oe = st_nxt.drive & ~st_r.oe_sync[1] & ~st_nxt.sleeping; // R5

    // ==========================================================
    // reset hold
    // everything waits in reset until the synchronised release arrives
    if (!rst_n_s) begin
      st_nxt = '0;
      st_nxt.rst_sync = {st_r.rst_sync[0], 1'b1};
    end
  end

  // ==========================================================
  // registers
  // reset is asynchronous at the pin; its release is synchronised through rst_sync
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // storage
  // memory has no reset; lanes not enabled keep their contents
  always_ff @(posedge sys_clk) begin
    if (rst_n_s && do_write) begin
      for (int i = 0; i < PSS_LANES; i++) begin
        if (lane_we[i]) begin
          mem_r[cur_addr][i*PSS_LANE_W +: PSS_LANE_W] <= dq_in[i*PSS_LANE_W +: PSS_LANE_W]; // R7
        end
      end
    end
  end

  // ==========================================================
  // outputs
  // every top-level output comes straight from st_r
  assign dq_out = st_r.q;
  assign dq_oe = st_r.oe;
  assign sleeping = st_r.sleeping;
  assign powered_up = st_r.powered_up;
endmodule : pss_sram_port
`default_nettype wire

// ==== pss_pkg.sv ====
`default_nettype none
package pss_pkg;
  localparam int PSS_ADDR_W = 16;
  localparam int PSS_LANE_W = 9;
  localparam int PSS_LANES = 2;
  localparam int PSS_DATA_W = PSS_LANE_W * PSS_LANES;
  // power-up wait before the first access is the controller's duty; the device only
  // tracks it so that early accesses are ignored
  localparam int PSS_CLK_HZ = 10_000_000;
  localparam int PSS_POWER_US = 1000;
  localparam int PSS_POWER_CYC = PSS_POWER_US * (PSS_CLK_HZ / 1_000_000);
  localparam logic [1:0] PSS_BURST_MASK = 2'h3;
endpackage : pss_pkg
`default_nettype wire

// ==== pss_lane_write.sv ====
`default_nettype none
// one byte lane: decides whether this lane takes the write data
module pss_lane_write
  import pss_pkg::*;
(
  input wire logic all_bytes_write_n,
  input wire logic byte_write_gate_n,
  input wire logic lane_write_n,
  output logic lane_we
);
  always_comb begin
    lane_we = ~all_bytes_write_n | (~byte_write_gate_n & ~lane_write_n); // R2 R7
  end
endmodule : pss_lane_write
`default_nettype wire

// ==== pss_sram_port_checker.sv ====
`default_nettype none
module pss_sram_port_checker
  import pss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic chip_enable_primary_n,
  input wire logic chip_enable_second,
  input wire logic chip_enable_third_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic all_bytes_write_n,
  input wire logic byte_write_gate_n,
  input wire logic [PSS_LANES-1:0] byte_lane_write_n,
  input wire logic output_enable_n,
  input wire logic dq_oe,
  input wire logic sleeping,
  input wire logic powered_up
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic sel;
  logic go;
  assign sel = !chip_enable_primary_n && chip_enable_second && !chip_enable_third_n;
  assign go = !ctrl_addr_strobe_n && powered_up && !sleeping;
  a_read_drives_bus: assert property (
    go && sel && !output_enable_n && all_bytes_write_n && (byte_write_gate_n || &byte_lane_write_n)
    |-> ##2 dq_oe)
    else $error("read not driven");
  // double-cycle deselect may keep the bus one extra cycle
  a_desel_no_drive: assert property (go && !sel |-> ##3 !dq_oe)
    else $error("deselected strobe drove bus");
  a_write_stays_hiz: assert property (
    go && sel && !all_bytes_write_n |-> ##2 !dq_oe ##1 !dq_oe) else $error("bus after write");
  a_lane_write_hiz: assert property (
    go && sel && all_bytes_write_n && !byte_write_gate_n && !(&byte_lane_write_n) |-> ##2 !dq_oe)
    else $error("bus after lane write");
  a_wake_hiz: assert property ($fell(sleeping) |-> !dq_oe) else $error("bus on wake");
  cover property (go && sel && !byte_write_gate_n);
  cover property (go && !sel);
  cover property ($fell(sleeping));
endmodule // pss_sram_port_checker
bind pss_sram_port pss_sram_port_checker chk_u (.sys_clk(sys_clk), .rst_b(rst_b),
  .chip_enable_primary_n(chip_enable_primary_n), .chip_enable_second(chip_enable_second),
  .chip_enable_third_n(chip_enable_third_n), .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
  .all_bytes_write_n(all_bytes_write_n), .byte_write_gate_n(byte_write_gate_n),
  .byte_lane_write_n(byte_lane_write_n), .output_enable_n(output_enable_n), .dq_oe(dq_oe),
  .sleeping(sleeping),
  .powered_up(powered_up));
`default_nettype wire

// ==== pss_ctrl_model.sv ====
`default_nettype none
module pss_ctrl_model
  import pss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic powered_up,
  output logic [2:0] ce,
  output logic cs_n,
  output logic [3:0] wr,
  output logic [PSS_ADDR_W-1:0] a,
  output logic [PSS_DATA_W-1:0] d,
  output logic zz
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {ce, cs_n, wr, a, d, zz} = {3'h4, 1'b1, 4'hF, 16'h0, 18'h0, 1'b0};
  task automatic cyc(input logic [2:0] c, input logic [3:0] w, input logic [15:0] ad,
      input logic [17:0] dd, input logic st);
    @(negedge sys_clk);
    {ce, wr, a, cs_n} = {c, w, ad, !st};
    // released data toggles so a stale value cannot pass as written
    d = st ? dd : ~d;
  endtask
  task automatic start();
    for (int n = 0; n < 50 && !powered_up; n++) @(negedge sys_clk);
  endtask
  task automatic nap(input logic on);
    if (on) cyc(3'h4, 4'hF, 16'h0, 18'h0, 1'b1);
    zz = on;
    repeat (8) @(negedge sys_clk);
  endtask
endmodule // pss_ctrl_model
`default_nettype wire

// ==== pipelined_sync_sram_port_test.sv ====
`default_nettype none
module pipelined_sync_sram_port_test;
  import pss_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] SEL = 3'h2;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] ce;
  logic [3:0] wr;
  logic [15:0] a;
  logic [17:0] d, q;
  logic cs_n, zz, dq_oe, sleeping, pwr;
  logic oe_n = 1'b0;
  int n_fail = 0;
  int n_checks = 0;
  int cyc_n = 0;
  initial forever #50 sys_clk = ~sys_clk;
  pss_ctrl_model m_u (.sys_clk(sys_clk), .powered_up(pwr), .ce(ce), .cs_n(cs_n), .wr(wr),
    .a(a), .d(d), .zz(zz));
  pss_sram_port #(.POWER_CYC(4)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .addr(a),
    .chip_enable_primary_n(ce[2]), .chip_enable_second(ce[1]), .chip_enable_third_n(ce[0]),
    .proc_addr_strobe_n(1'b1), .ctrl_addr_strobe_n(cs_n), .burst_advance_n(1'b1),
    .all_bytes_write_n(wr[3]), .byte_write_gate_n(wr[2]), .byte_lane_write_n(wr[1:0]),
    .output_enable_n(oe_n), .sleep_request(zz), .dq_in(d), .dq_out(q), .dq_oe(dq_oe),
    .sleeping(sleeping), .powered_up(pwr));
  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    n_checks++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      n_fail++;
    end
  endtask
  task automatic rd(input logic [15:0] ad, input logic [17:0] e);
    m_u.cyc(SEL, 4'hF, ad, 18'h0, 1'b1);
    repeat (2) m_u.cyc(SEL, 4'hF, ad, 18'h0, 1'b0);
    @(negedge sys_clk);
    chk(q, e);
    chk({17'h0, dq_oe}, 18'h1);
  endtask
  task automatic wt(input logic [2:0] c, input logic [3:0] w, input logic [15:0] ad,
      input logic [17:0] dd);
    m_u.cyc(c, w, ad, dd, 1'b1);
    m_u.cyc(SEL, 4'hF, ad, 18'h0, 1'b0);
  endtask
  task automatic t_lanes();
    wt(SEL, 4'h7, 16'h1, 18'h2A5A5);
    rd(16'h1, 18'h2A5A5);
    wt(SEL, 4'h8, 16'h2, 18'h15A5A);
    rd(16'h2, 18'h15A5A);
    wt(SEL, 4'h7, 16'h3, 18'h3FFFF);
    wt(SEL, 4'hA, 16'h3, 18'h0);
    rd(16'h3, 18'h3FE00);
    wt(SEL, 4'h9, 16'h3, 18'h0);
    wt(SEL, 4'hC, 16'h3, 18'h3FFFF);
    rd(16'h3, 18'h0);
  endtask
  task automatic t_desel();
    logic [2:0] p [3] = '{3'h6, 3'h0, 3'h3};
    for (int i = 0; i < 3; i++) begin
      wt(p[i], 4'h7, 16'h1, 18'h0);
      rd(16'h1, 18'h2A5A5);
    end
  endtask
  task automatic t_hiz_sleep();
    rd(16'h2, 18'h15A5A);
    wt(SEL, 4'h7, 16'h4, 18'h1);
    repeat (3) m_u.cyc(SEL, 4'hF, 16'h0, 18'h0, 1'b0);
    chk({17'h0, dq_oe}, 18'h0);
    rd(16'h4, 18'h1);
    oe_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk({17'h0, dq_oe}, 18'h0);
    oe_n = 1'b0;
    m_u.nap(1'b1);
    chk({17'h0, sleeping}, 18'h1);
    m_u.nap(1'b0);
    chk({17'h0, sleeping}, 18'h0);
    chk({17'h0, dq_oe}, 18'h0);
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========
  // sequence and hang guard
  always @(posedge sys_clk) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    rst_b = 1'b1;
    m_u.start();
    t_lanes();
    t_desel();
    t_hiz_sleep();
    stop_test();
  end
endmodule // pipelined_sync_sram_port_test
`default_nettype wire
